// ### hdl/sep_dev.sv
/*
  Device end: 1024 x 8 serial EEPROM array with read, page write, write
  latch, status read and a self-timed programming interval.
  Assumes the link pins are asynchronous to CLK and the serial clock
  half period is at least 6 CLK cycles; BLOCK_PROT comes from CLK logic.
*/
// Summary of operation
// [RULE_01] read: opcode, 16-bit address, then data out
// [RULE_02] serial input ignored after read address
// [RULE_03] only low ten address bits used
// [RULE_04] host ends single read by raising cs
// [RULE_05] read address increments while cs low
// [RULE_06] read address wraps to zero
// [RULE_07] write needs latch set command first
// [RULE_08] protected addresses are never programmed
// [RULE_09] busy: only status read accepted
// [RULE_10] write: opcode, address, data bytes
// [RULE_11] programming starts when cs rises
// [RULE_12] host raises cs in low time
// [RULE_13] page write increments low five bits
// [RULE_14] over 32 bytes overwrite earlier page bytes
// [RULE_15] latch clears when programming ends
// [RULE_16] write without latch discarded
// [RULE_17] new cs fall needed after discard
// [RULE_18] status bit 0 shows busy
// [RULE_19] sample on rise, shift out on fall
// [RULE_20] read and write opcode encodings
// [RULE_21] latch set opcode encoding
// [RULE_22] status reads all ones while busy
// [RULE_23] busy lasts a fixed timed interval
`timescale 1ns/1ps
module sep_dev #(
  parameter int TWC = sep_pkg::TWC_CYCLES
) (
  input wire logic CLK,
  input wire logic NRST,
  sep_link_if.dev LINK,
  input wire logic [1:0] BLOCK_PROT,
  output logic BUSY,
  output logic WRITE_EN
);
  localparam int AB = sep_pkg::ADDR_BITS;
  localparam int PB = sep_pkg::PAGE_BITS;
  localparam int TW = $clog2(TWC + 1);

  logic [7:0] mem [2**AB];
  logic [7:0] page [sep_pkg::PAGE_BYTES];
  sep_pkg::sep_dev_state_t st_q, st_d;
  logic cs_m_q, cs_s_q, sck_m_q, sck_s_q, sck_p_q, si_m_q, si_s_q;
  logic [15:0] sr_q, sr_d, sh;
  logic [4:0] cnt_q, cnt_d;
  logic [AB-1:0] addr_q, addr_d;
  logic [7:0] out_q, out_d, cmd_b, status;
  logic so_q, so_d, oe_q, oe_d, wel_q, wel_d, busy_q, busy_d, rd_q, rd_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [sep_pkg::PAGE_BYTES-1:0] fill_q, fill_d;
  logic rise, fall, sel, start, wstore;

  function automatic logic op_is(logic [7:0] b, logic [7:0] op);
    // bit 3 of every opcode is a don't-care
    op_is = ((b & sep_pkg::OP_MASK) == op); // [RULE_20] [RULE_21]
  endfunction

  function automatic logic guarded(logic [AB-1:0] a, logic [1:0] lvl);
    case (lvl)
      2'h0: guarded = 1'b0;
      2'h1: guarded = (a >= sep_pkg::PROT_QUARTER_BASE);
      2'h2: guarded = (a >= sep_pkg::PROT_HALF_BASE);
      default: guarded = 1'b1;
    endcase
  endfunction

  assign rise = sck_s_q & ~sck_p_q;
  assign fall = ~sck_s_q & sck_p_q;
  assign sel = ~cs_s_q;
  assign sh = {sr_q[14:0], si_s_q};
  assign cmd_b = sh[7:0];
  // all ones while programming, else live latch and protection level
  assign status = busy_q ? sep_pkg::ST_BUSY_VALUE : {4'h0, BLOCK_PROT, wel_q, 1'b0}; // [RULE_22]
  assign LINK.so = so_q;
  assign LINK.so_oe = oe_q;
  assign BUSY = busy_q;
  assign WRITE_EN = wel_q;

  always_comb
  begin
    st_d = st_q;
    sr_d = sr_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    out_d = out_q;
    so_d = so_q;
    oe_d = oe_q;
    wel_d = wel_q;
    busy_d = busy_q;
    rd_d = rd_q;
    tmr_d = tmr_q;
    fill_d = fill_q;
    start = 1'b0;
    wstore = 1'b0;
    if (busy_q)
    begin
      tmr_d = tmr_q - 1'b1;
      if (tmr_q == TW'(1))
      begin
        busy_d = 1'b0; // [RULE_23]
        wel_d = 1'b0; // [RULE_15]
      end
    end
    if (!sel)
    begin
      // a cut byte never starts programming
      if (st_q == sep_pkg::DS_WDATA && wel_q && fill_q != '0 && cnt_q == '0)
      begin
        start = 1'b1; // [RULE_11] [RULE_07]
        busy_d = 1'b1;
        tmr_d = TW'(TWC);
      end
      st_d = sep_pkg::DS_IDLE;
      oe_d = 1'b0;
    end
    else if (st_q == sep_pkg::DS_IDLE)
    begin
      // idle is left only through a fresh cs fall [RULE_17]
      st_d = sep_pkg::DS_CMD;
      cnt_d = '0;
    end
    else if (rise)
    begin
      sr_d = sh;
      cnt_d = cnt_q + 1'b1;
      case (st_q)
        sep_pkg::DS_CMD:
        begin
          if (cnt_q == 5'h07)
          begin
            cnt_d = '0;
            st_d = sep_pkg::DS_IGNORE;
            if (op_is(cmd_b, sep_pkg::OP_STATUS_READ))
            begin
              st_d = sep_pkg::DS_STAT;
              out_d = status; // [RULE_18]
            end
            else if (!busy_q) // [RULE_09]
            begin
              if (op_is(cmd_b, sep_pkg::OP_READ))
              begin
                st_d = sep_pkg::DS_ADDR; // [RULE_01]
                rd_d = 1'b1;
              end
              else if (op_is(cmd_b, sep_pkg::OP_WRITE) && wel_q) // [RULE_16]
              begin
                st_d = sep_pkg::DS_ADDR; // [RULE_10]
                rd_d = 1'b0;
              end
              else if (op_is(cmd_b, sep_pkg::OP_LATCH_SET))
              begin
                wel_d = 1'b1; // [RULE_07]
              end
              else if (op_is(cmd_b, sep_pkg::OP_LATCH_CLR))
              begin
                wel_d = 1'b0;
              end
            end
          end
        end
        sep_pkg::DS_ADDR:
        begin
          if (cnt_q == 5'h0f)
          begin
            cnt_d = '0;
            addr_d = sh[AB-1:0]; // [RULE_03]
            fill_d = '0;
            st_d = sep_pkg::DS_WDATA;
            if (rd_q)
            begin
              st_d = sep_pkg::DS_RDATA;
              out_d = mem[sh[AB-1:0]];
              addr_d = sh[AB-1:0] + 1'b1;
            end
          end
        end
        sep_pkg::DS_WDATA:
        begin
          if (cnt_q == 5'h07)
          begin
            cnt_d = '0;
            wstore = 1'b1;
            fill_d[addr_q[PB-1:0]] = 1'b1;
            // only the in-page bits count, so byte 33 lands on byte 1
            addr_d = {addr_q[AB-1:PB], addr_q[PB-1:0] + 1'b1}; // [RULE_13] [RULE_14]
          end
        end
        default:
        begin
          // data phases of reads and ignored frames: serial input is don't-care
          cnt_d = cnt_q; // [RULE_02]
        end
      endcase
    end
    else if (fall && (st_q == sep_pkg::DS_RDATA || st_q == sep_pkg::DS_STAT))
    begin
      so_d = out_q[7]; // [RULE_19]
      oe_d = 1'b1;
      out_d = {out_q[6:0], 1'b0};
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == 5'h07)
      begin
        cnt_d = '0;
        out_d = status;
        if (st_q == sep_pkg::DS_RDATA)
        begin
          out_d = mem[addr_q];
          addr_d = addr_q + 1'b1; // [RULE_05] [RULE_06]
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      si_m_q <= 1'b0;
      si_s_q <= 1'b0;
      st_q <= sep_pkg::DS_IDLE;
      sr_q <= '0;
      cnt_q <= '0;
      addr_q <= '0;
      out_q <= '0;
      so_q <= 1'b1;
      oe_q <= 1'b0;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      tmr_q <= '0;
      fill_q <= '0;
    end
    else
    begin
      cs_m_q <= LINK.cs_n;
      cs_s_q <= cs_m_q;
      sck_m_q <= LINK.sck;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      si_m_q <= LINK.si;
      si_s_q <= si_m_q;
      st_q <= st_d;
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      out_q <= out_d;
      so_q <= so_d;
      oe_q <= oe_d;
      wel_q <= wel_d;
      busy_q <= busy_d;
      rd_q <= rd_d;
      tmr_q <= tmr_d;
      fill_q <= fill_d;
    end
  end

  // page buffer collects bytes; the array is updated only when cs rises
  always_ff @(posedge CLK)
  begin
    if (wstore)
    begin
      page[addr_q[PB-1:0]] <= sh[7:0];
    end
    if (start)
    begin
      for (int i = 0; i < sep_pkg::PAGE_BYTES; i++)
      begin
        if (fill_q[i] && !guarded({addr_q[AB-1:PB], PB'(i)}, BLOCK_PROT)) // [RULE_08]
        begin
          mem[{addr_q[AB-1:PB], PB'(i)}] <= page[i];
        end
      end
    end
  end
endmodule

// ### hdl/sep_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH of at least 2; full and empty are registered flags.
*/
`timescale 1ns/1ps
module sep_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  assign push = in_valid & ~full_q;
  assign pop = out_ready & ~empty_q;
  assign in_ready = ~full_q;
  assign out_valid = ~empty_q;
  assign out_data = mem[rp_q];

  always_comb
  begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push)
    begin
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop)
    begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
    full_d = (cnt_d == (AW + 1)'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

// ### hdl/sep_host.sv
/*
  Host end: runs one serial frame per accepted command, makes the serial
  clock from CLK, feeds write bytes from a 4-word FIFO.
  Assumes the user issues the latch-set command before a write.
*/
`timescale 1ns/1ps
module sep_host #(
  parameter int HALF = sep_pkg::SCK_HALF_CYCLES,
  parameter int GAP = sep_pkg::CS_GAP_CYCLES,
  parameter int FDEPTH = sep_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic NRST,
  sep_link_if.host LINK,
  input wire logic CMD_VALID,
  input wire sep_pkg::sep_op_t CMD_OP,
  input wire logic [15:0] CMD_ADDR,
  input wire logic [7:0] CMD_LEN,
  output logic CMD_READY,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  output logic WR_READY,
  output logic RD_VALID,
  output logic [7:0] RD_DATA
);
  sep_pkg::sep_host_state_t st_q, st_d;
  sep_pkg::sep_op_t op_q, op_d;
  logic [7:0] div_q, div_d, tx_q, tx_d, rx_d, rdd_q, rdd_d;
  logic [2:0] bit_q, bit_d;
  logic [8:0] nbyte_q, nbyte_d, total_q, total_d, hdr;
  logic [15:0] addr_q, addr_d;
  logic cs_q, cs_d, sck_q, sck_d, si_q, si_d, rdy_q, rdy_d, rdv_q, rdv_d;
  logic so_m_q, so_s_q, f_valid, f_pop;
  logic [7:0] f_data;

  sep_fifo #(.W(8), .DEPTH(FDEPTH)) u_wr_fifo (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(WR_VALID),
    .in_ready(WR_READY),
    .in_data(WR_DATA),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  function automatic logic [7:0] opcode(sep_pkg::sep_op_t op);
    case (op)
      sep_pkg::SEP_OP_READ: opcode = sep_pkg::OP_READ;
      sep_pkg::SEP_OP_WRITE: opcode = sep_pkg::OP_WRITE;
      sep_pkg::SEP_OP_LATCH_SET: opcode = sep_pkg::OP_LATCH_SET;
      default: opcode = sep_pkg::OP_STATUS_READ;
    endcase
  endfunction

  assign LINK.cs_n = cs_q;
  assign LINK.sck = sck_q;
  assign LINK.si = si_q;
  assign CMD_READY = rdy_q;
  assign RD_VALID = rdv_q;
  assign RD_DATA = rdd_q;
  assign hdr = (op_q == sep_pkg::SEP_OP_READ || op_q == sep_pkg::SEP_OP_WRITE) ? 9'h003 : 9'h001;

  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    div_d = div_q;
    tx_d = tx_q;
    bit_d = bit_q;
    nbyte_d = nbyte_q;
    total_d = total_q;
    addr_d = addr_q;
    cs_d = cs_q;
    sck_d = sck_q;
    si_d = si_q;
    rdy_d = rdy_q;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    f_pop = 1'b0;
    rx_d = {tx_q[6:0], so_s_q};
    case (st_q)
      sep_pkg::HS_IDLE:
      begin
        if (CMD_VALID && rdy_q)
        begin
          // frame: opcode, 16-bit address, bytes MSB first [RULE_01] [RULE_10]
          op_d = CMD_OP;
          addr_d = CMD_ADDR;
          tx_d = opcode(CMD_OP); // [RULE_20] [RULE_21]
          si_d = tx_d[7];
          case (CMD_OP)
            sep_pkg::SEP_OP_LATCH_SET: total_d = 9'h001;
            sep_pkg::SEP_OP_STATUS: total_d = 9'h001 + {1'b0, CMD_LEN};
            default: total_d = 9'h003 + {1'b0, CMD_LEN};
          endcase
          nbyte_d = '0;
          bit_d = '0;
          cs_d = 1'b0;
          rdy_d = 1'b0;
          div_d = 8'(HALF);
          st_d = sep_pkg::HS_LOW;
        end
      end
      sep_pkg::HS_LOW:
      begin
        div_d = div_q - 1'b1;
        if (div_q == 8'h01)
        begin
          sck_d = 1'b1; // device samples si on this rise [RULE_19]
          div_d = 8'(HALF);
          st_d = sep_pkg::HS_HIGH;
        end
      end
      sep_pkg::HS_HIGH:
      begin
        div_d = div_q - 1'b1;
        if (div_q == 8'h01)
        begin
          // sample so just before the fall, before the device moves it
          sck_d = 1'b0;
          div_d = 8'(HALF);
          bit_d = bit_q + 1'b1;
          tx_d = rx_d;
          si_d = tx_q[6];
          st_d = sep_pkg::HS_LOW;
          if (bit_q == 3'h7)
          begin
            if (op_q != sep_pkg::SEP_OP_WRITE && nbyte_q >= hdr)
            begin
              rdv_d = 1'b1;
              rdd_d = rx_d;
            end
            nbyte_d = nbyte_q + 1'b1;
            if (nbyte_d == total_q)
            begin
              // cs rises in the low time after the last bit [RULE_12] [RULE_04]
              st_d = sep_pkg::HS_TAIL;
            end
            else if (op_q == sep_pkg::SEP_OP_WRITE && nbyte_d >= 9'h003)
            begin
              st_d = sep_pkg::HS_WAIT;
              div_d = 8'h01;
            end
            else
            begin
              tx_d = (nbyte_d == 9'h001) ? addr_q[15:8] : addr_q[7:0];
              if (nbyte_d >= hdr)
              begin
                tx_d = 8'h00;
              end
              si_d = tx_d[7];
            end
          end
        end
      end
      sep_pkg::HS_WAIT:
      begin
        // sck held low while the FIFO is empty
        if (f_valid)
        begin
          f_pop = 1'b1;
          tx_d = f_data;
          si_d = f_data[7];
          div_d = 8'(HALF);
          st_d = sep_pkg::HS_LOW;
        end
      end
      sep_pkg::HS_TAIL:
      begin
        div_d = div_q - 1'b1;
        if (div_q == 8'h01)
        begin
          cs_d = 1'b1;
          div_d = 8'(GAP);
          st_d = sep_pkg::HS_GAP;
        end
      end
      default:
      begin
        // every frame ends with a full cs high time [RULE_17]
        div_d = div_q - 1'b1;
        if (div_q == 8'h01)
        begin
          rdy_d = 1'b1;
          st_d = sep_pkg::HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q <= sep_pkg::HS_IDLE;
      op_q <= sep_pkg::SEP_OP_READ;
      div_q <= '0;
      tx_q <= '0;
      bit_q <= '0;
      nbyte_q <= '0;
      total_q <= '0;
      addr_q <= '0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      rdy_q <= 1'b1;
      rdv_q <= 1'b0;
      rdd_q <= '0;
      so_m_q <= 1'b1;
      so_s_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      div_q <= div_d;
      tx_q <= tx_d;
      bit_q <= bit_d;
      nbyte_q <= nbyte_d;
      total_q <= total_d;
      addr_q <= addr_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
      si_q <= si_d;
      rdy_q <= rdy_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
      so_m_q <= LINK.so_line;
      so_s_q <= so_m_q;
    end
  end
endmodule

// ### hdl/sep_link_if.sv
/*
  Serial link between host and EEPROM device ends.
  Assumes the serial output floats high when undriven (pull-up).
*/
`timescale 1ns/1ps
interface sep_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // resolved serial output wire as seen by the host
  assign so_line = so_oe ? so : 1'b1;

  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so_line);
endinterface

// ### hdl/sep_pkg.sv
/*
  Shared constants and types for the serial EEPROM link: opcodes, timing
  counts, address layout and the host command set. Assumes a 200 MHz CLK.
*/
package sep_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // self-timed programming interval (longest time, rounds down)
  localparam int TWC_NS = 5000000;
  localparam int TWC_CYCLES = TWC_NS / CLK_PERIOD_NS;
  // serial clock half period made by the host (least time, rounds up)
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // chip select high time between frames (least time, rounds up)
  localparam int CS_GAP_NS = 100;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 4;
  localparam int ADDR_BITS = 10;
  localparam int PAGE_BITS = 5;
  localparam int PAGE_BYTES = 32;
  // opcodes, bit 3 is ignored by the device
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_MASK = 8'hf7;
  // status byte layout
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LSB = 2;
  localparam logic [7:0] ST_BUSY_VALUE = 8'hff;
  // block protection lower bounds
  localparam logic [9:0] PROT_QUARTER_BASE = 10'h300;
  localparam logic [9:0] PROT_HALF_BASE = 10'h200;

  typedef enum logic [1:0] {
    SEP_OP_READ = 2'h0,
    SEP_OP_WRITE = 2'h1,
    SEP_OP_LATCH_SET = 2'h2,
    SEP_OP_STATUS = 2'h3
  } sep_op_t;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_CMD = 3'h1,
    DS_ADDR = 3'h3,
    DS_RDATA = 3'h2,
    DS_WDATA = 3'h6,
    DS_STAT = 3'h7,
    DS_IGNORE = 3'h5
  } sep_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_LOW = 3'h1,
    HS_HIGH = 3'h3,
    HS_TAIL = 3'h2,
    HS_GAP = 3'h6,
    HS_WAIT = 3'h7
  } sep_host_state_t;
endpackage

// ### test/sep_link_sva.sv
/* link checks on the serial wires; assumes sck is made from CLK by the host */
`timescale 1ns/1ps
module sep_link_sva (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic sck_q;
  logic [9:0] bits_q;
  logic [9:0] bits_d;
  // wraps freely: byte alignment still shows in the low bits
  always_comb
  begin
    bits_d = bits_q;
    if (cs_n)
      bits_d = 10'h000;
    else if (sck && !sck_q)
      bits_d = bits_q + 10'h001;
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sck_q <= 1'b0;
      bits_q <= 10'h000;
    end
    else
    begin
      sck_q <= sck;
      bits_q <= bits_d;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_oe_idle;
    cs_n [*8] |-> !so_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("so driven while idle");
  property p_oe_off;
    $rose(cs_n) |-> ##[1:6] !so_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("so not released");
  property p_so_fall;
    so_oe && $past(so_oe) && $changed(so) |-> !sck;
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved in sck high");
  property p_si_hold;
    sck && $past(sck) |-> $stable(si);
  endproperty
  a_si_hold: assert property (p_si_hold) else $error("si moved in sck high");
  property p_oe_late;
    $rose(so_oe) |-> bits_q >= 10'd8;
  endproperty
  a_oe_late: assert property (p_oe_late) else $error("so driven in opcode");
  property p_end_low;
    $rose(cs_n) |-> !sck;
  endproperty
  a_end_low: assert property (p_end_low) else $error("cs rose in sck high");
  property p_end_byte;
    $rose(cs_n) |-> bits_q[2:0] == 3'h0;
  endproperty
  a_end_byte: assert property (p_end_byte) else $error("cs rose mid byte");
  property p_start_low;
    $fell(cs_n) |-> !sck;
  endproperty
  a_start_low: assert property (p_start_low) else $error("cs fell in sck high");
endmodule

// ### test/testbench.sv
/* bench: host and device joined by the link; drives the host user side */
`timescale 1ns/1ps
module testbench;
  localparam int LIM = 20000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  sep_pkg::sep_op_t cmd_op = sep_pkg::SEP_OP_READ;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic cmd_ready;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [1:0] prot = 2'h0;
  logic busy;
  logic wen;
  logic [7:0] mem [1024];
  logic [7:0] exp_q [$];
  logic [15:0] pa [3] = '{16'h03ff, 16'h02f0, 16'h0000};
  int bad_count = 0;
  int compares = 0;
  sep_link_if link ();
  sep_host i_sep_host (.CLK(clk), .NRST(nrst), .LINK(link), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_READY(cmd_ready),
    .WR_VALID(wr_valid), .WR_DATA(wr_data), .WR_READY(wr_ready),
    .RD_VALID(rd_valid), .RD_DATA(rd_data));
  // short programming time keeps the run small
  sep_dev #(.TWC(2000)) i_sep_dev (.CLK(clk), .NRST(nrst), .LINK(link),
    .BLOCK_PROT(prot), .BUSY(busy), .WRITE_EN(wen));
  sep_link_sva i_sep_link_sva (.CLK(clk), .NRST(nrst), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .so(link.so), .so_oe(link.so_oe));
  initial forever #2.5 clk = ~clk;

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout();
    bad_count++;
    $display("MISMATCH wait expected done seen timeout");
    end_of_test();
  endtask
  task automatic cmd(input sep_pkg::sep_op_t op, input logic [15:0] a, input logic [7:0] n);
    int k;
    k = 0;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (cmd_ready !== 1'b1 && k < LIM);
    cmd_valid <= 1'b0;
    if (k >= LIM)
      timeout();
  endtask
  task automatic settle(input bit idle);
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    while ((cmd_ready !== 1'b1 || link.cs_n !== 1'b1 || exp_q.size() != 0
      || (idle && busy !== 1'b0)) && k < LIM)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= LIM)
      timeout();
  endtask
  task automatic feed(input logic [7:0] b [$]);
    int k;
    foreach (b[i])
    begin
      wr_data <= b[i];
      wr_valid <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (wr_ready !== 1'b1 && k < LIM);
      if (k >= LIM)
        timeout();
    end
    wr_valid <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input int n, input bit take);
    logic [7:0] b [$];
    for (int i = 0; i < n; i++)
    begin
      b.push_back(8'($urandom()));
      if (take)
        mem[{a[9:5], 5'(a[4:0] + 5'(i))}] = b[i];
    end
    fork
      cmd(sep_pkg::SEP_OP_WRITE, a, 8'(n));
      feed(b);
    join
    settle(1'b0);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++)
      exp_q.push_back(mem[10'(a + 16'(i))]);
    cmd(sep_pkg::SEP_OP_READ, a, 8'(n));
    settle(1'b0);
  endtask
  task automatic stat(input logic [7:0] e);
    exp_q.push_back(e);
    cmd(sep_pkg::SEP_OP_STATUS, 16'h0000, 8'h01);
    settle(1'b0);
  endtask
  task automatic latch();
    cmd(sep_pkg::SEP_OP_LATCH_SET, 16'h0000, 8'h00);
    settle(1'b1);
  endtask

  always @(posedge clk)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare byte", 8'hxx, rd_data);
      else
        chk("read byte", exp_q.pop_front(), rd_data);
    end

  initial
  begin
    void'($urandom(76605));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("latch at start", 8'h00, {7'h00, wen});
    wr(16'h0010, 1, 1'b0);
    settle(1'b1);
    stat(8'h00);
    $display("test discarded write done");
    latch();
    chk("latch set", 8'h01, {7'h00, wen});
    stat(8'h02);
    wr(16'hfc3e, 34, 1'b1);
    repeat (8) @(posedge clk);
    chk("busy", 8'h01, {7'h00, busy});
    stat(8'hff);
    latch();
    chk("latch after program", 8'h00, {7'h00, wen});
    stat(8'h00);
    rd(16'hfc20, 32);
    $display("test page write done");
    for (int p = 0; p < 4; p++)
    begin
      prot <= 2'(p);
      foreach (pa[j])
      begin
        latch();
        wr(pa[j], 1, p < j + 1);
        settle(1'b1);
        rd(pa[j], 1);
      end
    end
    $display("test protection done");
    prot <= 2'h0;
    rd(16'h03ff, 2);
    $display("test read wrap done");
    end_of_test();
  end
endmodule
